// >>> rtl/wdt_timer.sv
/*
  watchdog/interval timer core with password-protected word writes and byte reads.
  assumes the cpu bus presents address, write strobe with word flag, and read strobe
  in one cycle; read data is registered one cycle later.
*/
module wdt_timer (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic hw_standby_in,
  input wire logic sw_standby_in,
  input wire logic [15:0] addr_in,
  input wire logic wr_in,
  input wire logic word_in,
  input wire logic [15:0] wdata_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic interval_interrupt_request_out,
  output logic chip_reset_out,
  output logic reset_type_select_out
);
  logic [7:0] wdt_count_reg;
  logic [7:0] wdt_count_next;
  logic overflow_flag_reg;
  logic overflow_flag_next;
  logic mode_select_reg;
  logic timer_enable_reg;
  logic [2:0] clock_select_reg;
  logic watchdog_overflow_flag_reg;
  logic watchdog_overflow_flag_next;
  logic reset_enable_reg;
  logic reset_type_select_reg;
  logic ovf_armed_reg;
  logic watchdog_overflow_flag_armed_reg;
  logic [7:0] block_reg;
  logic [7:0] rdata_reg;
  logic tick;
  logic pulse_active;
  logic [7:0] cs_value;
  logic [7:0] rc_value;
  logic blocked;
  logic word_wr;
  logic wr_cs_addr;
  logic wr_rc_addr;
  logic key_cnt;
  logic key_cs;
  logic wr_cnt;
  logic wr_cs;
  logic wr_rc_flag;
  logic wr_rc_ctrl;
  logic inc;
  logic wrap;
  logic wd_wrap;
  logic wd_soft;
  logic trig;
  logic rd_cs;
  logic rd_rc;
  logic [7:0] rd_mux;
  logic [9:0] rst_run_reg;
  // ----------------------------------------
  // prescaler and reset stretcher
  // ----------------------------------------
  wdt_prescaler u_pre (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .hw_standby_in(hw_standby_in),
    .sel_in(clock_select_reg),
    .tick_out(tick)
  );
  wdt_reset_pulse u_pulse (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .trig_in(trig),
    .active_out(pulse_active)
  );
  // ----------------------------------------
  // write decode
  // ----------------------------------------
  assign blocked = (block_reg != 8'h00);
  assign word_wr = wr_in && word_in && !blocked;
  assign wr_cs_addr = word_wr && (addr_in == wdt_pkg::WDT_ADDR_CS_WR);
  assign wr_rc_addr = word_wr && (addr_in == wdt_pkg::WDT_ADDR_RC_WR);
  assign key_cnt = (wdata_in[15:8] == wdt_pkg::WDT_KEY_CNT);
  assign key_cs = (wdata_in[15:8] == wdt_pkg::WDT_KEY_CS);
  assign wr_cnt = wr_cs_addr && key_cnt;
  assign wr_cs = wr_cs_addr && key_cs;
  assign wr_rc_flag = wr_rc_addr && key_cs && (wdata_in[7:0] == 8'h00);
  assign wr_rc_ctrl = wr_rc_addr && key_cnt;
  // ----------------------------------------
  // counting and overflow
  // ----------------------------------------
  assign inc = tick && timer_enable_reg && !sw_standby_in;
  assign wrap = inc && !wr_cnt && (wdt_count_reg == wdt_pkg::WDT_CNT_MAX);
  assign wd_wrap = wrap && mode_select_reg;
  assign trig = wd_wrap && reset_enable_reg;
  assign wd_soft = wd_wrap && !reset_enable_reg;
  always_comb
  begin
    wdt_count_next = wdt_count_reg;
    if (wr_cnt)
      wdt_count_next = wdata_in[7:0];
    else if (inc)
      wdt_count_next = wdt_count_reg + 8'h01;
    if (!timer_enable_reg || wd_soft || trig || (wr_cs && !wdata_in[wdt_pkg::WDT_BIT_TME]))
      wdt_count_next = 8'h00;
  end
  always_comb
  begin
    overflow_flag_next = overflow_flag_reg;
    if (wr_cs && !wdata_in[wdt_pkg::WDT_BIT_FLAG] && ovf_armed_reg)
      overflow_flag_next = 1'b0;
    if (wrap)
      overflow_flag_next = 1'b1;
    if (trig || wd_soft)
      overflow_flag_next = 1'b0;
  end
  always_comb
  begin
    watchdog_overflow_flag_next = watchdog_overflow_flag_reg;
    if (wr_rc_flag && watchdog_overflow_flag_armed_reg)
      watchdog_overflow_flag_next = 1'b0;
    if (wd_wrap)
      watchdog_overflow_flag_next = 1'b1;
  end
  // ----------------------------------------
  // read path
  // ----------------------------------------
  assign cs_value = {overflow_flag_reg, mode_select_reg, timer_enable_reg, 2'b11, clock_select_reg}
                    | wdt_pkg::WDT_CS_RSVD;
  assign rc_value = {watchdog_overflow_flag_reg, reset_enable_reg, reset_type_select_reg, 5'h00}
                    | wdt_pkg::WDT_RC_RSVD;
  assign rd_cs = rd_in && (addr_in == wdt_pkg::WDT_ADDR_CS_RD);
  assign rd_rc = rd_in && (addr_in == wdt_pkg::WDT_ADDR_RC_RD);
  assign rd_mux = rd_cs ? cs_value :
                  (rd_in && addr_in == wdt_pkg::WDT_ADDR_CNT_RD) ? wdt_count_reg :
                  rd_rc ? rc_value : 8'h00;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wdt_count_reg <= 8'h00;
      overflow_flag_reg <= 1'b0;
      mode_select_reg <= 1'b0;
      timer_enable_reg <= 1'b0;
      clock_select_reg <= 3'h0;
      ovf_armed_reg <= 1'b0;
    end
    else if (hw_standby_in || trig || wd_soft)
    begin
      wdt_count_reg <= 8'h00;
      overflow_flag_reg <= 1'b0;
      mode_select_reg <= 1'b0;
      timer_enable_reg <= 1'b0;
      clock_select_reg <= 3'h0;
      ovf_armed_reg <= 1'b0;
    end
    else
    begin
      wdt_count_reg <= wdt_count_next;
      overflow_flag_reg <= overflow_flag_next;
      if (wr_cs)
      begin
        mode_select_reg <= wdata_in[wdt_pkg::WDT_BIT_MODE];
        timer_enable_reg <= wdata_in[wdt_pkg::WDT_BIT_TME];
        clock_select_reg <= wdata_in[2:0];
      end
      if (rd_cs && overflow_flag_reg)
        ovf_armed_reg <= 1'b1;
      else if (!overflow_flag_next)
        ovf_armed_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      watchdog_overflow_flag_reg <= 1'b0;
      reset_enable_reg <= 1'b0;
      reset_type_select_reg <= 1'b0;
      watchdog_overflow_flag_armed_reg <= 1'b0;
      block_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end
    else
    begin
      watchdog_overflow_flag_reg <= watchdog_overflow_flag_next;
      if (wr_rc_ctrl)
      begin
        reset_enable_reg <= wdata_in[wdt_pkg::WDT_BIT_RESET_ENABLE];
        reset_type_select_reg <= wdata_in[wdt_pkg::WDT_BIT_RESET_TYPE_SELECT];
      end
      if (rd_rc && watchdog_overflow_flag_reg && !blocked)
        watchdog_overflow_flag_armed_reg <= 1'b1;
      else if (!watchdog_overflow_flag_next)
        watchdog_overflow_flag_armed_reg <= 1'b0;
      if (wrap)
        block_reg <= wdt_pkg::WDT_BLOCK_CNT;
      else if (blocked)
        block_reg <= block_reg - 8'h01;
      if (rd_in)
        rdata_reg <= rd_mux;
    end
  end
  assign rdata_out = rdata_reg;
  assign interval_interrupt_request_out = overflow_flag_reg && !mode_select_reg;
  assign chip_reset_out = pulse_active;
  assign reset_type_select_out = reset_type_select_reg;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_wrap_sets_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wrap && !mode_select_reg && !hw_standby_in |=> overflow_flag_reg)
    else $error("wrap did not set overflow flag");
  chk_disable_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !timer_enable_reg |=> wdt_count_reg == 8'h00)
    else $error("counter not held at zero");
  chk_interval_no_watchdog_overflow_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !$past(watchdog_overflow_flag_reg) && watchdog_overflow_flag_reg |-> $past(wd_wrap))
    else $error("watchdog flag set without watchdog wrap");
  chk_byte_ignored: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr_in && !word_in && timer_enable_reg && !inc && !hw_standby_in |=> $stable(wdt_count_reg))
    else $error("byte write changed counter");
  chk_cnt_key: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr_cnt && timer_enable_reg && !hw_standby_in |=> wdt_count_reg == $past(wdata_in[7:0]))
    else $error("counter write lost");
  chk_block_window: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wrap |=> blocked [*8])
    else $error("write block window too short");
  chk_reset_trig: assert property (@(posedge clk_in) disable iff (!rstn_in)
    trig |-> ##[1:2] chip_reset_out)
    else $error("chip reset not raised");
  chk_rsvd_ones: assert property (@(posedge clk_in) disable iff (!rstn_in)
    rd_cs |=> rdata_out[4:3] == 2'b11)
    else $error("reserved bits not one");
  // length of the running chip reset pulse
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rst_run_reg <= 10'h000;
    else if (chip_reset_out)
      rst_run_reg <= rst_run_reg + 10'h001;
    else
      rst_run_reg <= 10'h000;
  end
  chk_pulse_run: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $fell(chip_reset_out) |-> rst_run_reg == wdt_pkg::WDT_RST_CNT)
    else $error("chip reset pulse length wrong");
  chk_count_step: assert property (@(posedge clk_in) disable iff (!rstn_in)
    inc && !wr_cnt && !wr_cs && !hw_standby_in && wdt_count_reg != wdt_pkg::WDT_CNT_MAX
    |=> wdt_count_reg == $past(wdt_count_reg) + 8'h01)
    else $error("counter did not step");
  chk_count_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    timer_enable_reg && !inc && !wr_cnt && !wr_cs && !hw_standby_in |=> $stable(wdt_count_reg))
    else $error("counter moved without tick");
  chk_wrap_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wrap && !hw_standby_in |=> wdt_count_reg == 8'h00)
    else $error("wrap did not reach zero");
  chk_hw_standby: assert property (@(posedge clk_in) disable iff (!rstn_in)
    hw_standby_in |=> wdt_count_reg == 8'h00 && cs_value == wdt_pkg::WDT_CS_RESET)
    else $error("hardware standby did not reset");
  chk_sw_freeze: assert property (@(posedge clk_in) disable iff (!rstn_in)
    sw_standby_in && !wr_cnt && !wr_cs && !hw_standby_in |=> $stable(wdt_count_reg))
    else $error("counter moved in software standby");
  chk_ovf_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $fell(overflow_flag_reg) |-> ($past(wr_cs) && $past(ovf_armed_reg)) || $past(trig) || $past(wd_soft)
    || $past(hw_standby_in))
    else $error("overflow flag cleared without cause");
  chk_irq_on_wrap: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wrap && !mode_select_reg && !wr_cs && !hw_standby_in |=> interval_interrupt_request_out)
    else $error("interval request missing after wrap");
  chk_rsvd_rc: assert property (@(posedge clk_in) disable iff (!rstn_in)
    rd_rc |=> (rdata_out & wdt_pkg::WDT_RC_RSVD) == wdt_pkg::WDT_RC_RSVD)
    else $error("reset control reserved bits not one");
  chk_rc_keep: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !wr_rc_ctrl |=> $stable(reset_enable_reg) && $stable(reset_type_select_reg))
    else $error("reset control changed without write");
  chk_watchdog_overflow_flag_set: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wd_wrap |=> watchdog_overflow_flag_reg)
    else $error("watchdog flag not set on wrap");
  chk_watchdog_overflow_flag_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $fell(watchdog_overflow_flag_reg) |-> $past(wr_rc_flag) && $past(watchdog_overflow_flag_armed_reg))
    else $error("watchdog flag cleared without armed write");
  chk_soft_reset: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wd_soft && !chip_reset_out |=> !chip_reset_out && wdt_count_reg == 8'h00
    && cs_value == wdt_pkg::WDT_CS_RESET)
    else $error("soft watchdog reset wrong");
  chk_byte_no_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr_in && !word_in && !hw_standby_in && !wrap |=> $stable(mode_select_reg) && $stable(timer_enable_reg)
    && $stable(clock_select_reg) && $stable(reset_enable_reg) && $stable(reset_type_select_reg))
    else $error("byte write changed a register");
  chk_cs_route: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr_cs && !hw_standby_in && !wrap |=> clock_select_reg == $past(wdata_in[2:0])
    && mode_select_reg == $past(wdata_in[wdt_pkg::WDT_BIT_MODE]))
    else $error("control write lost");
  chk_flag_only: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr_rc_flag && watchdog_overflow_flag_armed_reg && !wd_wrap |=> !watchdog_overflow_flag_reg && $stable(reset_enable_reg)
    && $stable(reset_type_select_reg))
    else $error("flag clear write wrong");
  chk_rc_load: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr_rc_ctrl && !wd_wrap |=> reset_enable_reg == $past(wdata_in[wdt_pkg::WDT_BIT_RESET_ENABLE])
    && reset_type_select_reg == $past(wdata_in[wdt_pkg::WDT_BIT_RESET_TYPE_SELECT]) && $stable(watchdog_overflow_flag_reg))
    else $error("reset control load wrong");
  chk_cnt_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
    rd_in && addr_in == wdt_pkg::WDT_ADDR_CNT_RD |=> rdata_out == $past(wdt_count_reg))
    else $error("counter read wrong");
  chk_block_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
    rd_rc && blocked && !watchdog_overflow_flag_armed_reg |=> !watchdog_overflow_flag_armed_reg)
    else $error("blocked read armed the flag");
  chk_block_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr_in && blocked && !hw_standby_in && !wrap |=> $stable(mode_select_reg) && $stable(reset_enable_reg)
    && $stable(watchdog_overflow_flag_reg))
    else $error("write taken inside block window");
  chk_key_unknown: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wr_in && word_in && !key_cnt && !key_cs && !hw_standby_in && !wrap |=> $stable(mode_select_reg)
    && $stable(clock_select_reg) && $stable(reset_enable_reg) && $stable(reset_type_select_reg))
    else $error("unknown key write taken");
endmodule : wdt_timer

// >>> rtl/wdt_pkg.sv
/*
  package of constants for the watchdog/interval timer: addresses, keys,
  field positions, reset values and timing counts.
  assumes a single 250 MHz system clock; one state equals one clock cycle.
*/
// Functional notes
// - 8-bit up-counter counts selected prescaled pulses
// - wrap ff to 00 sets overflow flag
// - counter zeroed by reset, hw standby, disable
// - control/status resets to 0x18, kept in sw standby
// - overflow flag cleared by read-1 then write-0
// - internal watchdog reset clears overflow flag
// - bit 6 selects interval or watchdog mode
// - bit 5 enables counting, zero holds counter
// - reserved bits read one, ignore writes
// - clock select picks one of eight dividers
// - reset control reset only by external pin
// - watchdog flag set only on watchdog-mode wrap
// - watchdog flag cleared by read-1 then write-0
// - reset enable gates chip reset on overflow
// - reset select picks power-on or manual
// - byte writes to counter/control ignored
// - key 5a to counter, a5 to control
// - reset control written by word only
// - key a5 with 00 clears watchdog flag only
// - key 5a loads reset enable and select
// - byte reads at ff74, ff75, ff77
// - internal reset held for 518 states
// - writes and flag reads blocked 132 states; overflow flag reads still arm the clear
// - pin reset beats watchdog reset, clears flag
// - counter write beats coincident increment
package wdt_pkg;
  localparam logic [15:0] WDT_ADDR_CS_WR = 16'hff74;
  localparam logic [15:0] WDT_ADDR_CS_RD = 16'hff74;
  localparam logic [15:0] WDT_ADDR_CNT_RD = 16'hff75;
  localparam logic [15:0] WDT_ADDR_RC_WR = 16'hff76;
  localparam logic [15:0] WDT_ADDR_RC_RD = 16'hff77;
  localparam logic [7:0] WDT_KEY_CNT = 8'h5a;
  localparam logic [7:0] WDT_KEY_CS = 8'ha5;
  localparam logic [7:0] WDT_CS_RESET = 8'h18;
  localparam logic [7:0] WDT_RC_RESET = 8'h1f;
  localparam logic [7:0] WDT_CS_RSVD = 8'h18;
  localparam logic [7:0] WDT_RC_RSVD = 8'h1f;
  localparam logic [7:0] WDT_CNT_MAX = 8'hff;
  localparam int WDT_BIT_FLAG = 7;
  localparam int WDT_BIT_MODE = 6;
  localparam int WDT_BIT_TME = 5;
  localparam int WDT_BIT_RESET_ENABLE = 6;
  localparam int WDT_BIT_RESET_TYPE_SELECT = 5;
  localparam int WDT_PRE_W = 17;
  localparam int WDT_CLK_MHZ = 250;
  localparam int WDT_STATE_NS = 4;
  localparam int WDT_RST_STATES = 518;
  localparam int WDT_BLOCK_STATES = 132;
  localparam int WDT_RST_CYC = (WDT_RST_STATES * WDT_STATE_NS * WDT_CLK_MHZ + 999) / 1000;
  localparam int WDT_BLOCK_CYC = (WDT_BLOCK_STATES * WDT_STATE_NS * WDT_CLK_MHZ + 999) / 1000;
  localparam logic [9:0] WDT_RST_CNT = 10'(WDT_RST_CYC);
  localparam logic [7:0] WDT_BLOCK_CNT = 8'(WDT_BLOCK_CYC);
endpackage : wdt_pkg

// >>> rtl/wdt_prescaler.sv
/*
  free-running prescaler giving a one-cycle tick at the selected division.
  assumes the select only changes while the counter is stopped.
*/
module wdt_prescaler (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic hw_standby_in,
  input wire logic [2:0] sel_in,
  output logic tick_out
);
  logic [wdt_pkg::WDT_PRE_W-1:0] pre_reg;
  logic [wdt_pkg::WDT_PRE_W-1:0] pre_next;
  logic [wdt_pkg::WDT_PRE_W-1:0] mask;
  // ----------------------------------------
  // divider mask per select code
  // ----------------------------------------
  function automatic logic [wdt_pkg::WDT_PRE_W-1:0] div_mask(input logic [2:0] s);
    case (s)
      3'h0: div_mask = 17'h00001;
      3'h1: div_mask = 17'h0003f;
      3'h2: div_mask = 17'h0007f;
      3'h3: div_mask = 17'h001ff;
      3'h4: div_mask = 17'h007ff;
      3'h5: div_mask = 17'h01fff;
      3'h6: div_mask = 17'h07fff;
      default: div_mask = 17'h1ffff;
    endcase
  endfunction : div_mask
  assign mask = div_mask(sel_in);
  assign pre_next = pre_reg + 17'h00001;
  assign tick_out = ((pre_reg & mask) == mask);
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      pre_reg <= '0;
    else if (hw_standby_in)
      pre_reg <= '0;
    else
      pre_reg <= pre_next;
  end
endmodule : wdt_prescaler

// >>> rtl/wdt_reset_pulse.sv
/*
  stretches a one-cycle trigger into a fixed-length chip reset level.
  assumes the trigger is ignored while a pulse is already running.
*/
module wdt_reset_pulse (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic trig_in,
  output logic active_out
);
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  assign active_out = (cnt_reg != 10'h000);
  assign cnt_next = trig_in && !active_out ? wdt_pkg::WDT_RST_CNT :
                    active_out ? cnt_reg - 10'h001 : 10'h000;
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cnt_reg <= 10'h000;
    else
      cnt_reg <= cnt_next;
  end
  chk_pulse_length: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(active_out) |-> active_out [*8])
    else $error("reset pulse too short");
endmodule : wdt_reset_pulse

// >>> test/wdt_cpu_model.sv
/*
  cpu side of the internal bus: keyed word writes, byte reads, read polling.
  assumes the timer takes strobes on the rising edge and registers read data.
*/
module wdt_cpu_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [15:0] addr_out,
  output logic wr_out,
  output logic word_out,
  output logic [15:0] wdata_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  initial
  begin
    addr_out = 16'h0000;
    wr_out = 1'b0;
    word_out = 1'b0;
    wdata_out = 16'h0000;
    rd_out = 1'b0;
  end
  // one write; released lines show the inverse of the last value
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    word_out = w;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    addr_out = ~a;
    q = rdata_in;
  endtask : rd
  // read strobe held for polling one address every cycle
  task automatic hold(input logic [15:0] a, input logic on);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = on;
  endtask : hold
endmodule : wdt_cpu_model

// >>> test/tb_top.sv
/*
  self-checking bench for the watchdog/interval timer with a register model.
  assumes the cpu model drives the bus and rstn_in comes from the pin only.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rstn_in, hw_standby_in, sw_standby_in, wr, word, rd, irq, chip_rst, rst_type;
  logic [15:0] addr, wdata;
  logic [7:0] rdata, q;
  int failures, checked, seed, exp_cs, exp_cnt, exp_rc, rst_cycles, n, v;
  int divs[6] = '{2, 64, 128, 512, 2048, 8192};
  logic [15:0] addrs[4] = '{16'hff74, 16'hff75, 16'hff77, 16'hff76};
  bit ign;
  wdt_timer u_wdt_timer (.clk_in(clk_in), .rstn_in(rstn_in), .hw_standby_in(hw_standby_in),
    .sw_standby_in(sw_standby_in), .addr_in(addr), .wr_in(wr), .word_in(word), .wdata_in(wdata),
    .rd_in(rd), .rdata_out(rdata), .interval_interrupt_request_out(irq), .chip_reset_out(chip_rst),
    .reset_type_select_out(rst_type));
  wdt_cpu_model u_wdt_cpu_model (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
    .word_out(word), .wdata_out(wdata), .rd_out(rd));
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(negedge clk_in)
    if (chip_rst === 1'b1)
      rst_cycles++;
  // ----------------------------------------
  // checking and register model
  // ----------------------------------------
  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_up;
    failures++;
    final_report();
  endtask : give_up
  function automatic int exp_rd(input logic [15:0] a);
    return a == 16'hff74 ? exp_cs : a == 16'hff75 ? exp_cnt : a == 16'hff77 ? exp_rc : 0;
  endfunction : exp_rd
  task automatic mwr(input logic [15:0] a, input logic [15:0] d, input logic w);
    u_wdt_cpu_model.wr(a, d, w);
    if (w && !ign && a == 16'hff74 && d[15:8] == 8'h5a && exp_cs[5])
      exp_cnt = d[7:0];
    if (w && !ign && a == 16'hff74 && d[15:8] == 8'ha5)
    begin
      exp_cs = {exp_cs[7] & d[7], d[6:5], 2'b11, d[2:0]};
      exp_cnt = d[5] ? exp_cnt : 0;
    end
    if (w && !ign && a == 16'hff76 && d == 16'ha500)
      exp_rc = exp_rc & 8'h7f;
    if (w && !ign && a == 16'hff76 && d[15:8] == 8'h5a)
      exp_rc = (exp_rc & 8'h80) | (d & 8'h60) | 8'h1f;
  endtask : mwr
  task automatic rd_all;
    foreach (addrs[i])
    begin
      u_wdt_cpu_model.rd(addrs[i], q);
      check(32'(q), 32'(exp_rd(addrs[i])));
    end
  endtask : rd_all
  // cycles until the polled count changes
  task automatic gap(output int k);
    q = rdata;
    k = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      k++;
    end
    while (rdata === q && k < 30000);
    if (k == 30000)
      give_up();
  endtask : gap
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    failures = 0;
    checked = 0;
    seed = 28;
    ign = 0;
    exp_cs = 8'h18;
    exp_cnt = 0;
    exp_rc = 8'h1f;
    rstn_in = 1'b0;
    hw_standby_in = 1'b0;
    sw_standby_in = 1'b0;
    repeat (12) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    rd_all();
    mwr(16'hff74, 16'ha520, 0);
    mwr(16'hff74, 16'h3c20, 1);
    mwr(16'hff76, 16'h5a60, 0);
    rd_all();
    sw_standby_in = 1'b1;
    mwr(16'hff74, 16'ha521, 1);
    v = $random(seed);
    mwr(16'hff74, {8'h5a, 8'(v)}, 1);
    repeat (600) @(posedge clk_in);
    rd_all();
    hw_standby_in = 1'b1;
    exp_cs = 8'h18;
    exp_cnt = 0;
    repeat (3) @(posedge clk_in);
    #1 hw_standby_in = 1'b0;
    sw_standby_in = 1'b0;
    rd_all();
    for (int c = 0; c < 6; c++)
    begin
      mwr(16'hff74, 16'ha520 | 16'(c), 1);
      u_wdt_cpu_model.hold(16'hff75, 1'b1);
      repeat (3) gap(n);
      check(32'(n), 32'(divs[c]));
      u_wdt_cpu_model.hold(16'hff75, 1'b0);
      mwr(16'hff74, 16'ha500, 1);
    end
    mwr(16'hff74, 16'ha520, 1);
    mwr(16'hff74, 16'h5afe, 1);
    for (n = 0; n < 20 && irq !== 1'b1; n++)
    begin
      @(posedge clk_in);
      #1;
    end
    if (n == 20)
      give_up();
    check(32'(irq), 32'd1);
    exp_cs = 8'hb8;
    repeat (140) @(posedge clk_in);
    u_wdt_cpu_model.rd(16'hff74, q);
    check(32'(q), 32'(exp_cs));
    mwr(16'hff74, 16'ha500, 1);
    rd_all();
    check(32'(irq), 32'd0);
    for (int e = 0; e < 2; e++)
    begin
      mwr(16'hff76, e ? 16'h5a60 : 16'h5a20, 1);
      check(32'(rst_type), 32'd1);
      mwr(16'hff74, 16'ha560, 1);
      rst_cycles = 0;
      mwr(16'hff74, 16'h5afe, 1);
      repeat (12) @(posedge clk_in);
      ign = 1;
      mwr(16'hff74, 16'ha520, 1);
      u_wdt_cpu_model.rd(16'hff77, q);
      check(32'(q), 32'(exp_rc | 8'h80));
      repeat (700) @(posedge clk_in);
      mwr(16'hff76, 16'ha500, 1);
      ign = 0;
      check(32'(rst_cycles), e ? 32'd518 : 32'd0);
      check(32'(irq), 32'd0);
      exp_cs = 8'h18;
      exp_cnt = 0;
      exp_rc = exp_rc | 8'h80;
      rd_all();
      if (e == 0)
      begin
        rstn_in = 1'b0;
        exp_rc = 8'h1f;
        @(posedge clk_in);
        #1 rstn_in = 1'b1;
      end
      else
        mwr(16'hff76, 16'ha500, 1);
      rd_all();
    end
    final_report();
  end
endmodule : tb_top
